/* File: hdl/otnlo_pkg.sv */
// Function
// - five lanes, one 66-bit word each
// - alignment markers forwarded, never stripped
// - pcs lane n words on output n mod five
// - bip8 computed per lane over words
// - single clock, so plain pipeline, no fifo
// - lane count fixed at five, core clock
// - fec output used when fec configured
// - valid pattern: 33 high, one low
// - output always active, no enable control
// - gearbox path adds two cycles latency
// - first lane flag marks pcs lane 0
// - marker flag high on marker words
// - bip outputs carry parity during markers
// - sync header on top, payload below
// - no dedicated statistics ports or blocks
package otnlo_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int LANES = 5;
  localparam int PCS_LANES = 20;
  localparam int IDX_W = 5;
  localparam int BIP_W = 8;
  localparam int WORD_W = 66;
  localparam int HDR_HI = 65;
  localparam int HDR_LO = 64;

  // ****************************************
  // enable pattern and latency
  // ****************************************
  localparam int ENA_HIGH = 33;
  localparam logic [5:0] ENA_LAST = 6'(ENA_HIGH);
  localparam logic [5:0] CNT_RST = 6'h00;
  localparam int GEAR_LAT = 2;
  localparam logic [7:0] BIP_RST = 8'h00;

  // sync header in bits 65:64, payload below
  typedef struct packed {
    logic [1:0] sync_hdr;
    logic [63:0] payload;
  } otnlo_word_s;

  // one cycle of aligned words from the aligner or fec
  typedef struct packed {
    otnlo_word_s [LANES-1:0] word;
    logic [LANES-1:0][IDX_W-1:0] pcs_idx;
    logic marker;
  } otnlo_beat_s;

  // one cycle of the transport output
  typedef struct packed {
    otnlo_word_s [LANES-1:0] word;
    logic [LANES-1:0][BIP_W-1:0] parity;
    logic marker;
    logic first;
  } otnlo_out_s;

endpackage

/* File: hdl/otnlo_lane_output.sv */
`timescale 1ns/100ps
module otnlo_lane_output (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // receive stream after alignment and after fec
  input wire otnlo_pkg::otnlo_beat_s align_beat,
  input wire otnlo_pkg::otnlo_beat_s fec_beat,
  input wire logic fec_present,
  // pull strobe towards the aligner gearbox
  output logic word_take,
  // transport output
  output logic transport_ena,
  output logic first_lane_flag,
  output logic marker_flag,
  output otnlo_pkg::otnlo_word_s [otnlo_pkg::LANES-1:0] transport_data,
  output logic [otnlo_pkg::LANES-1:0][7:0] transport_lane_parity_n
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [2:0] slot_of(input logic [4:0] idx);
    slot_of = 3'(idx % 5'(otnlo_pkg::LANES));
  endfunction

  // bit j folds every eighth bit of the 66-bit word starting at j
  function automatic logic [7:0] fold8(input otnlo_pkg::otnlo_word_s w);
    logic [65:0] v;
    logic [7:0] r;
    v = w;
    r = otnlo_pkg::BIP_RST;
    for (int b = 0; b < otnlo_pkg::WORD_W; b++) begin
      r[b % otnlo_pkg::BIP_W] = r[b % otnlo_pkg::BIP_W] ^ v[b];
    end
    fold8 = r;
  endfunction

  // ****************************************
  // source select and enable pattern
  // ****************************************
  // the fec path is chosen whole, so corrected words keep their ids
  wire otnlo_pkg::otnlo_beat_s src = fec_present ? fec_beat : align_beat;

  logic [5:0] phase_reg;
  logic [5:0] phase_next;
  logic take_reg;
  logic [1:0] ena_pipe_reg;
  // free running: nothing can stop the output once out of reset
  assign phase_next = (phase_reg == otnlo_pkg::ENA_LAST) ?
                      otnlo_pkg::CNT_RST : phase_reg + 6'h01;
  wire take_next = (phase_next != otnlo_pkg::ENA_LAST);

  always_ff @(posedge clk) begin
    if (srst) begin
      phase_reg <= otnlo_pkg::CNT_RST;
      take_reg <= 1'b0;
      ena_pipe_reg <= 2'h0;
    end else begin
      phase_reg <= phase_next;
      take_reg <= take_next;
      ena_pipe_reg <= {ena_pipe_reg[0], take_reg};
    end
  end

  // ****************************************
  // reorder and parity (gearbox stage one)
  // ****************************************
  logic [otnlo_pkg::PCS_LANES-1:0][7:0] acc_reg;
  otnlo_pkg::otnlo_word_s [otnlo_pkg::LANES-1:0] ord_word;
  logic [otnlo_pkg::LANES-1:0][7:0] ord_par;
  logic [otnlo_pkg::LANES-1:0][7:0] word_par;
  logic ord_first;

  always_comb begin
    ord_word = '0;
    ord_par = '0;
    ord_first = 1'b0;
    for (int j = 0; j < otnlo_pkg::LANES; j++) begin
      word_par[j] = fold8(src.word[j]);
    end
    for (int j = 0; j < otnlo_pkg::LANES; j++) begin
      // word of pcs lane n lands on output n mod five
      ord_word[slot_of(src.pcs_idx[j])] = src.word[j];
      ord_par[slot_of(src.pcs_idx[j])] = acc_reg[src.pcs_idx[j]];
      if (src.pcs_idx[j] == 5'h00 && j == 0) begin
        ord_first = 1'b1;
      end
    end
    if (src.pcs_idx[0] == 5'h00 || slot_of(src.pcs_idx[0]) != 3'h0) begin
      ord_first = 1'b0;
      for (int j = 0; j < otnlo_pkg::LANES; j++) begin
        if (src.pcs_idx[j] == 5'h00) begin
          ord_first = 1'b1;
        end
      end
    end
  end

  // the marker closes a parity period and opens the next one
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_reg <= '0;
    end else if (take_reg) begin
      for (int j = 0; j < otnlo_pkg::LANES; j++) begin
        if (src.marker) begin
          acc_reg[src.pcs_idx[j]] <= word_par[j];
        end else begin
          acc_reg[src.pcs_idx[j]] <= acc_reg[src.pcs_idx[j]] ^ word_par[j];
        end
      end
    end
  end

  // ****************************************
  // stage registers
  // ****************************************
  otnlo_pkg::otnlo_out_s st1_reg;
  otnlo_pkg::otnlo_out_s st1_next;
  otnlo_pkg::otnlo_out_s st2_reg;
  otnlo_pkg::otnlo_out_s st2_next;

  always_comb begin
    st1_next.word = ord_word;
    st1_next.marker = take_reg & src.marker;
    st1_next.first = take_reg & ord_first;
    st1_next.parity = (take_reg & src.marker) ? ord_par : '0;
  end

  // second gearbox stage only qualifies; data are held when idle
  always_comb begin
    st2_next = st1_reg;
    st2_next.word = ena_pipe_reg[0] ? st1_reg.word : st2_reg.word;
  end

  // single clock domain: a plain two-stage pipeline, no fifo crossing
  always_ff @(posedge clk) begin
    if (srst) begin
      st1_reg <= '0;
      st2_reg <= '0;
    end else begin
      st1_reg <= st1_next;
      st2_reg <= st2_next;
    end
  end

  // statistics stay with the mac and pcs counters; nothing added here
  assign word_take = take_reg;
  assign transport_ena = ena_pipe_reg[1];
  assign first_lane_flag = st2_reg.first;
  assign marker_flag = st2_reg.marker;
  assign transport_data = st2_reg.word;
  assign transport_lane_parity_n = st2_reg.parity;

  // ****************************************
  // checks
  // ****************************************
  logic [5:0] run_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      run_reg <= otnlo_pkg::CNT_RST;
    end else begin
      run_reg <= transport_ena ? run_reg + 6'h01 : otnlo_pkg::CNT_RST;
    end
  end

  // the first run after reset is one short, so only full periods are judged
  logic gap_seen_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      gap_seen_reg <= 1'b0;
    end else if (run_reg != otnlo_pkg::CNT_RST && !transport_ena) begin
      gap_seen_reg <= 1'b1;
    end
  end

  // same count on the pull strobe, which leads the output by two cycles
  logic [5:0] take_run_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      take_run_reg <= otnlo_pkg::CNT_RST;
    end else begin
      take_run_reg <= word_take ?
                      take_run_reg + 6'h01 : otnlo_pkg::CNT_RST;
    end
  end

  // pcs lane 0 is carried by some slot of the beat being taken
  wire beat_has_lane0 = (src.pcs_idx[0] == 5'h00) ||
                        (src.pcs_idx[1] == 5'h00) ||
                        (src.pcs_idx[2] == 5'h00) ||
                        (src.pcs_idx[3] == 5'h00) ||
                        (src.pcs_idx[4] == 5'h00);

  sequence s_lane0_taken;
    word_take && src.pcs_idx[0] == 5'h00;
  endsequence

  sequence s_marker_lane0;
    word_take && src.marker && src.pcs_idx[0] == 5'h00;
  endsequence

  sequence s_plain_taken;
    word_take && !src.marker;
  endsequence

  sequence s_take_sent;
    word_take;
  endsequence

  sequence s_two_later;
    ##2 transport_ena;
  endsequence

  a_ena_run_length: assert property (@(posedge clk) disable iff (srst)
    ($fell(transport_ena) && gap_seen_reg) |->
      $past(run_reg) == 6'h20)
    else $error("valid run not 33 cycles");

  a_ena_single_gap: assert property (@(posedge clk) disable iff (srst)
    (!transport_ena && $past(transport_ena)) |=> transport_ena)
    else $error("valid low longer than one cycle");

  a_ena_no_long: assert property (@(posedge clk) disable iff (srst)
    run_reg <= 6'h21)
    else $error("valid high too long");

  a_gear_latency: assert property (@(posedge clk) disable iff (srst)
    s_take_sent |-> s_two_later)
    else $error("output not two cycles after take");

  a_marker_pass: assert property (@(posedge clk) disable iff (srst)
    (word_take && src.marker) |-> ##2 marker_flag)
    else $error("marker word not flagged");

  a_first_lane: assert property (@(posedge clk) disable iff (srst)
    (word_take && src.pcs_idx[0] == 5'h00) |-> ##2 first_lane_flag)
    else $error("lane zero flag missing");

  a_flags_qualified: assert property (
    @(posedge clk) disable iff (srst)
    !transport_ena |-> (!marker_flag && !first_lane_flag))
    else $error("flag outside valid");

  a_parity_quiet: assert property (@(posedge clk) disable iff (srst)
    !marker_flag |-> transport_lane_parity_n == '0)
    else $error("parity outside marker");

  a_lane0_order: assert property (@(posedge clk) disable iff (srst)
    (word_take && src.pcs_idx[0] == 5'h00) |->
      ##2 transport_data[0] == $past(src.word[0], 2))
    else $error("lane zero word misplaced");

  a_take_gap: assert property (@(posedge clk) disable iff (srst)
    (!word_take && $past(word_take)) |=> word_take)
    else $error("pull strobe low longer than one cycle");

  a_take_run: assert property (@(posedge clk) disable iff (srst)
    take_run_reg <= 6'h21)
    else $error("pull strobe high too long");

  a_ena_from_take: assert property (@(posedge clk) disable iff (srst)
    transport_ena |-> $past(word_take, 2))
    else $error("output valid without a take two cycles before");

  a_plain_marker: assert property (@(posedge clk) disable iff (srst)
    s_plain_taken |-> ##2 !marker_flag)
    else $error("data word flagged as marker");

  a_first_absent: assert property (@(posedge clk) disable iff (srst)
    (word_take && !beat_has_lane0) |-> ##2 !first_lane_flag)
    else $error("lane zero flag without lane zero word");

  a_first_found: assert property (@(posedge clk) disable iff (srst)
    (word_take && beat_has_lane0) |-> ##2 first_lane_flag)
    else $error("lane zero word not flagged");

  a_idle_hold: assert property (@(posedge clk) disable iff (srst)
    !transport_ena |-> $stable(transport_data))
    else $error("data changed in idle cycle");

  a_lane0_header: assert property (@(posedge clk) disable iff (srst)
    s_lane0_taken |->
      ##2 transport_data[0].sync_hdr == $past(src.word[0].sync_hdr, 2))
    else $error("sync header not on top bits");

  a_marker_words: assert property (@(posedge clk) disable iff (srst)
    s_marker_lane0 |->
      ##2 (marker_flag && transport_data[0] == $past(src.word[0], 2)))
    else $error("marker word not forwarded");

  a_bip_restart: assert property (@(posedge clk) disable iff (srst)
    s_marker_lane0 |=> acc_reg[0] == $past(word_par[0]))
    else $error("parity period not restarted at marker");

  a_bip_lane0: assert property (@(posedge clk) disable iff (srst)
    s_marker_lane0 |->
      ##2 transport_lane_parity_n[0] == $past(acc_reg[0], 2))
    else $error("lane zero parity not shown with marker");

endmodule

/* File: dv/otnlo_framer_model.sv */
`timescale 1ns/100ps
// ****************************************
// downstream framer: keeps only qualified beats
// ****************************************
module otnlo_framer_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // transport stream from the port
  input wire logic transport_ena,
  input wire logic first_lane_flag,
  input wire otnlo_pkg::otnlo_word_s [otnlo_pkg::LANES-1:0] transport_data,
  // last beat taken as valid
  output otnlo_pkg::otnlo_word_s [otnlo_pkg::LANES-1:0] seen_data,
  output logic seen_first
);
  // idle-cycle contents are held words, so they must never be captured
  always_ff @(posedge clk) begin
    if (srst) begin
      seen_data <= '0;
      seen_first <= 1'b0;
    end else if (transport_ena) begin
      seen_data <= transport_data;
      seen_first <= first_lane_flag;
    end
  end
endmodule

/* File: dv/otnlo_lane_output_bench.sv */
`timescale 1ns/100ps
module otnlo_lane_output_bench;
  logic clk, srst, fec_present, word_take, transport_ena;
  logic first_lane_flag, marker_flag, seen_first;
  otnlo_pkg::otnlo_beat_s align_beat, fec_beat, mark_b, data_b;
  otnlo_pkg::otnlo_word_s [otnlo_pkg::LANES-1:0] transport_data, seen_data;
  logic [otnlo_pkg::LANES-1:0][7:0] transport_lane_parity_n, exp_par;
  int mismatches, checks, n;
  int perm [5] = '{3, 0, 4, 1, 2};

  otnlo_lane_output u_dut (.clk(clk), .srst(srst), .align_beat(align_beat),
    .fec_beat(fec_beat), .fec_present(fec_present), .word_take(word_take),
    .transport_ena(transport_ena), .first_lane_flag(first_lane_flag),
    .marker_flag(marker_flag), .transport_data(transport_data),
    .transport_lane_parity_n(transport_lane_parity_n));
  otnlo_framer_model u_far (.clk(clk), .srst(srst),
    .transport_ena(transport_ena), .first_lane_flag(first_lane_flag),
    .transport_data(transport_data), .seen_data(seen_data),
    .seen_first(seen_first));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] bip(otnlo_pkg::otnlo_word_s w);
    logic [7:0] p;
    p = 8'h00;
    for (int b = 0; b < 66; b++) p[b % 8] ^= w[b];
    return p;
  endfunction
  // off = 5 keeps the slot mapping but removes pcs lane 0
  function automatic otnlo_pkg::otnlo_beat_s mk(logic [15:0] tag, logic m,
                                                int off);
    otnlo_pkg::otnlo_beat_s bt;
    for (int s = 0; s < 5; s++) begin
      bt.word[s] = {2'h1, tag, 48'(s)};
      bt.pcs_idx[s] = 5'(perm[s] + off);
    end
    bt.marker = m;
    return bt;
  endfunction
  function automatic logic [329:0] reord(otnlo_pkg::otnlo_beat_s bt);
    otnlo_pkg::otnlo_word_s [otnlo_pkg::LANES-1:0] r;
    for (int s = 0; s < 5; s++) r[perm[s]] = bt.word[s];
    return r;
  endfunction
  task automatic cmp_bit(string nm, logic e, logic g);
    checks++;
    if (e !== g) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic cmp_vec(string nm, logic [329:0] e, logic [329:0] g);
    checks++;
    if (e !== g) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wait_take();
    n = 0;
    while (word_take !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic do_reset(logic fec);
    srst = 1'b1;
    fec_present = fec;
    repeat (10) @(negedge clk);
    srst = 1'b0;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reorder();
    wait_take();
    align_beat = mk(16'h1234, 1'b0, 0);
    repeat (2) @(negedge clk);
    cmp_bit("ena", 1'b1, transport_ena);
    cmp_vec("data", reord(align_beat), transport_data);
    cmp_bit("first", 1'b1, first_lane_flag);
    cmp_bit("marker", 1'b0, marker_flag);
    cmp_bit("take", 1'b1, word_take);
    @(negedge clk);
    cmp_vec("far data", reord(align_beat), seen_data);
    cmp_bit("far first", 1'b1, seen_first);
  endtask
  task automatic t_pattern();
    for (n = 0; n < 40 && transport_ena !== 1'b0; n++) @(negedge clk);
    if (n >= 40) begin
      mismatches++;
      summarize();
    end
    cmp_bit("idle first", 1'b0, first_lane_flag);
    cmp_bit("idle marker", 1'b0, marker_flag);
    @(negedge clk);
    for (n = 0; n < 40 && transport_ena === 1'b1; n++) @(negedge clk);
    cmp_vec("high run", 330'(33), 330'(n));
  endtask
  task automatic t_parity();
    wait_take();
    @(negedge clk);
    fec_beat = data_b;
    @(negedge clk);
    fec_beat = mark_b;
    cmp_bit("marker out", 1'b1, marker_flag);
    cmp_vec("cleared bip", 330'(0), 330'(transport_lane_parity_n));
    repeat (2) @(negedge clk);
    for (int s = 0; s < 5; s++)
      exp_par[perm[s]] = bip(mark_b.word[s]) ^ bip(data_b.word[s]);
    cmp_bit("marker again", 1'b1, marker_flag);
    cmp_vec("marker words", reord(mark_b), transport_data);
    cmp_vec("bip", 330'(exp_par), 330'(transport_lane_parity_n));
  endtask
  task automatic t_fec();
    wait_take();
    fec_beat = mk(16'hBEEF, 1'b0, 5);
    repeat (2) @(negedge clk);
    cmp_vec("fec data", reord(fec_beat), transport_data);
    cmp_bit("no lane 0", 1'b0, first_lane_flag);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    mismatches = 0;
    checks = 0;
    srst = 1'b1;
    fec_present = 1'b0;
    mark_b = mk(16'hC0DE, 1'b1, 0);
    data_b = mk(16'h5A3C, 1'b0, 0);
    align_beat = mk(16'h0000, 1'b0, 0);
    fec_beat = mark_b;
    do_reset(1'b0);
    t_reorder();
    t_pattern();
    align_beat = mk(16'hDEAD, 1'b0, 0);
    do_reset(1'b1);
    t_parity();
    t_fec();
    summarize();
  end
endmodule
